// *** core/rcivec_consts.vh ***
// Constants for the reset cause and interrupt vectoring block.
`ifndef RCIVEC_CONSTS_VH
`define RCIVEC_CONSTS_VH
// Register port offsets.
`define RCIV_ADDR_CAUSE 4'h0
`define RCIV_ADDR_CTRL 4'h1
`define RCIV_ADDR_PEND 4'h2
`define RCIV_ADDR_PEND_HI 4'h3
// Reset cause bit positions.
`define RCIV_BIT_BROWNOUT 1
`define RCIV_BIT_BADADDR 3
`define RCIV_BIT_BADOP 4
`define RCIV_BIT_WDOG 5
`define RCIV_BIT_PIN 6
`define RCIV_BIT_POR 7
`define RCIV_CAUSE_RESET 8'h80
// Control register bit positions.
`define RCIV_CTRL_HALT_OK 0
// Timing, in oscillator clocks.
`define RCIV_PIN_LOW_CLKS 6'h20
`define RCIV_HOLD_CLKS 6'h20
`define RCIV_PIN_SAMPLE_CLKS 6'h20
`define RCIV_BROWNOUT_CLKS 7'h40
// Vectors and priorities.
`define RCIV_VEC_RESET 16'hFFFE
`define RCIV_VEC_TRAP 16'hFFFC
`define RCIV_VEC_TOP 16'hFFFA
`define RCIV_NUM_SRC 16
`endif

// *** core/rciv_core.v ***
// Reset cause recorder and prioritised interrupt vectoring unit.
//
// Contract
// - Unknown opcode resets and sets bad-opcode flag
// - Halt forbidden by option acts as bad opcode
// - Fetch from unmapped address resets, flags it
// - Unmapped data reads never reset
// - Cause register read-only, cleared by read
// - Power-up leaves only power-on flag set
// - Pin low 32 clocks after release sets pin flag
// - Cause flags accumulate until read
// - Brownout releases after 64 clocks, sets flag
// - Watchdog timeout sets watchdog flag
// - External pin reset sets external flag
// - Interrupt entry waits for instruction end
// - Entry stacks registers; return pops them (block pops nothing; return_exec only counts as an instruction end)
// - Entry sets global mask; no preemption
// - Highest-priority pending request serviced first
// - Pending request served before next program instruction
// - High index byte is never stacked
// - Priority zero highest; sources one to sixteen
// - Fixed two-byte vector per source (levels 14 and 15 share the FFDE pair here)
// - Request needs flag and enable; mask blocks
// - Software trap is not maskable
// - Trap stacks PC, hardware stacks PC minus one
// - Pin low 32 clocks, then 32 more held
`timescale 1ns/1ps
`include "rcivec_consts.vh"
module rciv_core (
    // Clock and reset.
    input wire clk,
    input wire resetn,
    // Register port.
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // Reset event sources.
    input wire bad_opcode,
    input wire halt_exec,
    input wire fetch_unmapped,
    input wire data_read_unmapped,
    input wire watchdog_timeout,
    input wire brownout_n,
    // Reset pin, open drain.
    input wire rst_pin_in,
    output wire rst_pin_out,
    output wire rst_pin_oe,
    output wire cpu_reset,
    // Peripheral requests: flag and enable, index 0 is priority 1.
    input wire [15:0] src_flag,
    input wire [15:0] src_enable,
    // CPU side.
    input wire instr_done,
    input wire trap_exec,
    input wire return_exec,
    input wire global_mask,
    input wire [15:0] cpu_pc,
    input wire [15:0] cpu_sp,
    input wire [7:0] cpu_xl,
    input wire [7:0] cpu_acc,
    input wire [7:0] cpu_ccr,
    output reg int_entry,
    output reg [15:0] vector_addr,
    output reg [4:0] int_level,
    output reg set_global_mask,
    output reg stack_we,
    output reg [15:0] stack_addr,
    output reg [7:0] stack_data,
    output reg stack_busy
);

////////////////////////////////////////////////////////////////////////
// Reset sequencer.

// The sequencer wakes from power-on in the pin phase, so power-on
// follows the same pin-low then hold timing as any internal reset.
localparam RS_RUN = 2'h0;
localparam RS_PIN = 2'h1;
localparam RS_HOLD = 2'h2;

reg [1:0] rs_state_ff;
reg [6:0] rs_cnt_ff;
reg [7:0] cause_ff;
reg halt_ok_ff;
reg sample_pend_ff;
reg [5:0] sample_cnt_ff;
reg pin_s1_ff;
reg pin_s2_ff;
reg bo_s1_ff;
reg bo_s2_ff;
reg [7:0] nxt_cause;

wire halt_bad = halt_exec & ~halt_ok_ff;
// Unmapped data reads deliberately absent from the trigger.
wire int_reset_evt = bad_opcode | halt_bad | fetch_unmapped |
    watchdog_timeout | ~bo_s2_ff;
wire running = (rs_state_ff == RS_RUN);
// Every read of the cause register clears it, even a read issued only
// to poll; there is no way to look without clearing.
wire cause_read = reg_rd & (reg_addr == `RCIV_ADDR_CAUSE);

// The pin is open drain: the block only ever pulls it low, and the
// pull-up outside brings it back high.
assign rst_pin_out = 1'b0;
assign rst_pin_oe = ~running & (rs_state_ff == RS_PIN);
assign cpu_reset = ~running;

// Both asynchronous levels pass two flops; they reset to their idle
// high level so that leaving reset is not mistaken for a pin event.
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        pin_s1_ff <= 1'b1;
        pin_s2_ff <= 1'b1;
        bo_s1_ff <= 1'b1;
        bo_s2_ff <= 1'b1;
    end else begin
        pin_s1_ff <= rst_pin_in;
        pin_s2_ff <= pin_s1_ff;
        bo_s1_ff <= brownout_n;
        bo_s2_ff <= bo_s1_ff;
    end
end

always @* begin
    nxt_cause = cause_ff;
    if (cause_read) begin
        nxt_cause = 8'h00;
    end
    // Sets are OR'ed after the clear so a simultaneous event survives.
    if (running && bad_opcode) begin
        nxt_cause[`RCIV_BIT_BADOP] = 1'b1;
    end
    if (running && halt_bad) begin
        nxt_cause[`RCIV_BIT_BADOP] = 1'b1;
    end
    if (running && fetch_unmapped) begin
        nxt_cause[`RCIV_BIT_BADADDR] = 1'b1;
    end
    if (running && watchdog_timeout) begin
        nxt_cause[`RCIV_BIT_WDOG] = 1'b1;
    end
    if (!bo_s2_ff) begin
        nxt_cause[`RCIV_BIT_BROWNOUT] = 1'b1;
    end
    if (running && !pin_s2_ff) begin
        nxt_cause[`RCIV_BIT_PIN] = 1'b1;
    end
    if (sample_pend_ff && sample_cnt_ff == 6'h00 && !pin_s2_ff) begin
        nxt_cause[`RCIV_BIT_PIN] = 1'b1;
    end
end

always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        rs_state_ff <= RS_PIN;
        rs_cnt_ff <= 7'h00;
        cause_ff <= `RCIV_CAUSE_RESET;
        halt_ok_ff <= 1'b0;
        sample_pend_ff <= 1'b0;
        sample_cnt_ff <= 6'h00;
    end else begin
        cause_ff <= nxt_cause;
        // Only the halt permit bit is writable; writes aimed at the
        // cause register are dropped because it is read-only.
        if (reg_wr && reg_addr == `RCIV_ADDR_CTRL) begin
            halt_ok_ff <= reg_wdata[`RCIV_CTRL_HALT_OK];
        end
        // The pin is looked at once, a fixed time after release, so a
        // slow outside driver still holding it low is recorded.
        if (sample_pend_ff) begin
            if (sample_cnt_ff == 6'h00) begin
                sample_pend_ff <= 1'b0;
            end else begin
                sample_cnt_ff <= sample_cnt_ff - 6'h01;
            end
        end
        case (rs_state_ff)
            RS_RUN: begin
                if (int_reset_evt) begin
                    rs_state_ff <= RS_PIN;
                    rs_cnt_ff <= 7'h00;
                end
            end
            RS_PIN: begin
                // A supply still low keeps the pin phase going; the
                // count restarts once the supply is back.
                if (!bo_s2_ff) begin
                    rs_cnt_ff <= 7'h00;
                end else if (rs_cnt_ff ==
                    {1'b0, `RCIV_PIN_LOW_CLKS} - 7'h01) begin
                    rs_state_ff <= RS_HOLD;
                    rs_cnt_ff <= 7'h00;
                    sample_pend_ff <= 1'b1;
                    sample_cnt_ff <= `RCIV_PIN_SAMPLE_CLKS - 6'h01;
                end else begin
                    rs_cnt_ff <= rs_cnt_ff + 7'h01;
                end
            end
            RS_HOLD: begin
                // Pin-low plus hold equals the 64-clock brownout release.
                if (rs_cnt_ff ==
                    {1'b0, `RCIV_HOLD_CLKS} - 7'h01) begin
                    rs_state_ff <= RS_RUN;
                end else begin
                    rs_cnt_ff <= rs_cnt_ff + 7'h01;
                end
            end
            default: begin
                rs_state_ff <= RS_PIN;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// Register read port.

// A source asks only while its flag and its enable are both set.
wire [15:0] pending = src_flag & src_enable;

// Read data stand for one cycle only and fall back to zero, so a
// stale value is never mistaken for a fresh read.
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        reg_rdata <= 8'h00;
    end else if (reg_rd) begin
        case (reg_addr)
            `RCIV_ADDR_CAUSE: reg_rdata <= cause_ff;
            `RCIV_ADDR_CTRL: reg_rdata <= {7'h00, halt_ok_ff};
            `RCIV_ADDR_PEND: reg_rdata <= pending[7:0];
            `RCIV_ADDR_PEND_HI: reg_rdata <= pending[15:8];
            default: reg_rdata <= 8'h00;
        endcase
    end else begin
        reg_rdata <= 8'h00;
    end
end

////////////////////////////////////////////////////////////////////////
// Interrupt arbitration and stacking.

// Lowest set index wins; returns 1-based level, 0 when none.
function [4:0] rciv_pick;
    input [15:0] req;
    integer i;
    begin
        rciv_pick = 5'h00;
        for (i = `RCIV_NUM_SRC - 1; i >= 0; i = i - 1) begin
            if (req[i]) begin
                rciv_pick = i[4:0] + 5'h01;
            end
        end
    end
endfunction

// Vector pairs step down two bytes per level from the pin vector.
function [15:0] rciv_vec;
    input [4:0] lvl;
    begin
        // The keypad and conversion sources share one pair, and the
        // pair below the last serial vector is skipped.
        if (lvl == 5'h0E || lvl == 5'h0F) begin
            rciv_vec = `RCIV_VEC_TOP - 16'h001C;
        end else begin
            rciv_vec = `RCIV_VEC_TOP - {10'h000, lvl - 5'h01, 1'b0};
        end
    end
endfunction

// Stacking is done here, one byte a cycle, so a frame costs five
// cycles after the instruction end is taken.
localparam IS_IDLE = 1'b0;
localparam IS_STACK = 1'b1;

reg is_state_ff;
reg [2:0] byte_ff;
reg [15:0] spc_ff;
reg [15:0] ssp_ff;
reg [7:0] sx_ff;
reg [7:0] sa_ff;
reg [7:0] sc_ff;
reg [15:0] svec_ff;
reg [4:0] slvl_ff;
reg [7:0] nxt_stack_data;

wire [4:0] hw_lvl = rciv_pick(pending);
// The return is an instruction end of its own; accepting either
// strobe keeps a core that flags only the return working.
wire instr_end = instr_done | return_exec;
// Checked at every instruction end outside a stacking frame, including the return, so a
// pending request is taken before the interrupted program resumes.
wire boundary = running & instr_end & ~stack_busy;
wire take_trap = boundary & trap_exec;
wire take_hw = boundary & ~trap_exec & ~global_mask &
    (hw_lvl != 5'h00);

// Byte for the slot written next; it is registered beside stack_addr so
// the memory sees address and data launched by the same edge.
always @* begin
    case (byte_ff)
        3'h0: nxt_stack_data = spc_ff[7:0];
        3'h1: nxt_stack_data = spc_ff[15:8];
        3'h2: nxt_stack_data = sx_ff;
        3'h3: nxt_stack_data = sa_ff;
        default: nxt_stack_data = sc_ff;
    endcase
end

always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        is_state_ff <= IS_IDLE;
        byte_ff <= 3'h0;
        spc_ff <= 16'h0000;
        ssp_ff <= 16'h0000;
        sx_ff <= 8'h00;
        sa_ff <= 8'h00;
        sc_ff <= 8'h00;
        svec_ff <= `RCIV_VEC_RESET;
        slvl_ff <= 5'h00;
        stack_busy <= 1'b0;
        stack_we <= 1'b0;
        stack_addr <= 16'h0000;
        stack_data <= 8'h00;
        int_entry <= 1'b0;
        vector_addr <= `RCIV_VEC_RESET;
        int_level <= 5'h00;
        set_global_mask <= 1'b0;
    end else begin
        int_entry <= 1'b0;
        set_global_mask <= 1'b0;
        stack_we <= 1'b0;
        case (is_state_ff)
            IS_IDLE: begin
                if (take_trap || take_hw) begin
                    is_state_ff <= IS_STACK;
                    stack_busy <= 1'b1;
                    byte_ff <= 3'h0;
                    spc_ff <= take_trap ? cpu_pc
                        : cpu_pc - 16'h0001;
                    ssp_ff <= cpu_sp;
                    sx_ff <= cpu_xl;
                    sa_ff <= cpu_acc;
                    sc_ff <= cpu_ccr;
                    svec_ff <= take_trap ? `RCIV_VEC_TRAP
                        : rciv_vec(hw_lvl);
                    slvl_ff <= take_trap ? 5'h00 : hw_lvl;
                end
            end
            // Busy stays high for the whole frame, so an instruction end
            // that arrives meanwhile is ignored rather than queued.
            IS_STACK: begin
                stack_we <= 1'b1;
                stack_addr <= ssp_ff;
                stack_data <= nxt_stack_data;
                ssp_ff <= ssp_ff - 16'h0001;
                if (byte_ff == 3'h4) begin
                    is_state_ff <= IS_IDLE;
                    stack_busy <= 1'b0;
                    int_entry <= 1'b1;
                    vector_addr <= svec_ff;
                    int_level <= slvl_ff;
                    set_global_mask <= 1'b1;
                end
                byte_ff <= byte_ff + 3'h1;
            end
            default: begin
                is_state_ff <= IS_IDLE;
            end
        endcase
    end
end

endmodule

// *** test/rciv_core_properties.sv ***
// Concurrent checks on the ports of the reset cause and vectoring block.
`timescale 1ns/1ps
`include "rcivec_consts.vh"
module rciv_props (
    input logic clk, resetn, reg_rd, bad_opcode, fetch_unmapped,
    input logic data_read_unmapped, watchdog_timeout, halt_exec,
    input logic brownout_n, rst_pin_oe, cpu_reset, instr_done, trap_exec,
    input logic global_mask, stack_busy, stack_we, int_entry,
    input logic set_global_mask,
    input logic [3:0] reg_addr,
    input logic [7:0] reg_rdata,
    input logic [4:0] int_level,
    input logic [15:0] vector_addr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    badop_rst_a: assert property (
        bad_opcode && !cpu_reset |=> cpu_reset && rst_pin_oe)
        else $error("no reset after bad opcode");
    fetch_rst_a: assert property (
        fetch_unmapped && !cpu_reset |=> cpu_reset)
        else $error("no reset after bad fetch");
    data_rd_a: assert property (
        data_read_unmapped && !cpu_reset && !(bad_opcode |
        fetch_unmapped | watchdog_timeout | halt_exec) |=> !cpu_reset)
        else $error("data read caused reset");
    // A supply dip stretches the pin phase, so the exact length is
    // checked only for phases that begin with the supply good.
    pin_low_a: assert property (
        $rose(rst_pin_oe) && brownout_n |-> ##31 rst_pin_oe ##1 !rst_pin_oe)
        else $error("pin low phase not 32 clocks");
    pin_min_a: assert property (
        $fell(rst_pin_oe) |-> $past(rst_pin_oe, 32))
        else $error("pin low phase shorter than 32 clocks");
    hold_a: assert property (
        $fell(rst_pin_oe) |-> ##31 cpu_reset ##1 !cpu_reset)
        else $error("hold phase not 32 clocks");
    rd_idle_a: assert property (
        !(reg_rd && reg_addr < 4'h4) |=> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    trap_seq_a: assert property (
        instr_done && trap_exec && !stack_busy && !cpu_reset
        |=> stack_busy ##1 stack_we [*4] ##1 stack_we && int_entry)
        else $error("trap entry sequence wrong");
    entry_mask_a: assert property (int_entry |-> set_global_mask)
        else $error("entry without mask set");
    trap_vec_a: assert property (
        int_entry && int_level == 5'h00 |-> vector_addr == `RCIV_VEC_TRAP)
        else $error("level zero vector wrong");
    level_vec_a: assert property (
        int_entry && int_level == 5'h01 |-> vector_addr == `RCIV_VEC_TOP)
        else $error("level one vector wrong");
    mask_blk_a: assert property (
        instr_done && global_mask && !trap_exec && !stack_busy |=> !stack_busy)
        else $error("masked request taken");
endmodule
bind rciv_core rciv_props rciv_props_inst (.clk(clk), .resetn(resetn),
    .reg_rd(reg_rd), .bad_opcode(bad_opcode), .fetch_unmapped(fetch_unmapped),
    .data_read_unmapped(data_read_unmapped), .halt_exec(halt_exec),
    .watchdog_timeout(watchdog_timeout), .brownout_n(brownout_n),
    .rst_pin_oe(rst_pin_oe),
    .cpu_reset(cpu_reset), .instr_done(instr_done), .trap_exec(trap_exec),
    .global_mask(global_mask), .stack_busy(stack_busy), .stack_we(stack_we),
    .int_entry(int_entry), .set_global_mask(set_global_mask),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata), .int_level(int_level),
    .vector_addr(vector_addr));

// *** test/rciv_stack_model.sv ***
// Stack memory model standing in for the CPU side of the block.
`timescale 1ns/1ps
module rciv_stack_model (
    input logic clk,
    input logic stack_we,
    input logic [15:0] stack_addr,
    input logic [7:0] stack_data
);
    // Only the low nibble is decoded; the bench keeps every frame inside it.
    logic [7:0] mem [0:15];
    always @(posedge clk) begin
        if (stack_we) begin
            mem[stack_addr[3:0]] <= stack_data;
        end
    end
endmodule

// *** test/reset_cause_and_interrupt_vectoring_tb_top.sv ***
// Self-checking bench for the reset cause and vectoring block.
`timescale 1ns/1ps
`include "rcivec_consts.vh"
module reset_cause_and_interrupt_vectoring_tb_top;
    logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0, ev = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, stack_data;
    logic data_rd_bad = 1'b0, brownout_n = 1'b1, pin_ext_n = 1'b1;
    logic done = 1'b0, trap = 1'b0, ret = 1'b0, gmask = 1'b0;
    logic [15:0] flag = 16'h0000, en = 16'h0000, vector_addr, stack_addr;
    logic rst_pin_oe, cpu_reset, int_entry, stack_we, stack_busy, set_gmask;
    logic [4:0] int_level;
    int n_errors = 0, cmp_count = 0, cyc = 0;
    // Open-drain pin with a pull-up: low whenever any party pulls it.
    wire rst_pin_in = rst_pin_oe ? 1'b0 : pin_ext_n;
    always #50 clk = ~clk;
    rciv_core rciv_core_inst (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .bad_opcode(ev[0]), .halt_exec(ev[1]),
        .fetch_unmapped(ev[2]), .watchdog_timeout(ev[3]),
        .data_read_unmapped(data_rd_bad), .brownout_n(brownout_n),
        .rst_pin_in(rst_pin_in), .rst_pin_out(), .rst_pin_oe(rst_pin_oe),
        .cpu_reset(cpu_reset), .src_flag(flag), .src_enable(en),
        .instr_done(done), .trap_exec(trap), .return_exec(ret),
        .global_mask(gmask), .cpu_pc(16'h1234), .cpu_sp(16'h00F4),
        .cpu_xl(8'h56), .cpu_acc(8'h78), .cpu_ccr(8'h9A),
        .int_entry(int_entry), .vector_addr(vector_addr),
        .int_level(int_level), .set_global_mask(set_gmask),
        .stack_we(stack_we), .stack_addr(stack_addr), .stack_data(stack_data),
        .stack_busy(stack_busy));
    rciv_stack_model rciv_stack_model_inst (.clk(clk), .stack_we(stack_we),
        .stack_addr(stack_addr), .stack_data(stack_data));
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task fire(input int k);
        @(posedge clk);
        ev[k] <= 1'b1;
        @(posedge clk);
        ev <= 4'h0;
    endtask
    task run_wait();
        repeat (3) @(posedge clk);
        repeat (400) if (cpu_reset !== 1'b0) @(posedge clk);
        repeat (5) @(posedge clk);
        chk(cpu_reset, 1'b0);
    endtask
    task irq(input logic t, r, input logic [15:0] v, input logic [4:0] l,
        input logic [15:0] p);
        int k;
        logic [15:0] pair;
        repeat (3) @(posedge clk);
        chk(stack_busy, 1'b0);
        done <= 1'b1;
        trap <= t;
        ret <= r;
        @(posedge clk);
        done <= 1'b0;
        trap <= 1'b0;
        ret <= 1'b0;
        #1;
        for (k = 0; k < 12 && int_entry !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        chk(int_entry, v != 16'h0000);
        if (v != 16'h0000) begin
            chk(vector_addr, v);
            chk(int_level, l);
            chk(set_gmask, 1'b1);
            @(posedge clk);
            #1;
            pair = {rciv_stack_model_inst.mem[3],
                rciv_stack_model_inst.mem[4]};
            chk(pair, p);
            chk(rciv_stack_model_inst.mem[2], 8'h56);
            pair = {rciv_stack_model_inst.mem[1],
                rciv_stack_model_inst.mem[0]};
            chk(pair, 16'h789A);
        end
    endtask
    task src(input logic [15:0] f, e, input logic m);
        @(posedge clk);
        flag <= f;
        en <= e;
        gmask <= m;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_por();
        run_wait();
        rd_chk(`RCIV_ADDR_CAUSE, 8'h80);
        rd_chk(`RCIV_ADDR_CAUSE, 8'h00);
        rd_chk(4'h9, 8'h00);
    endtask
    task t_accum();
        fire(0);
        run_wait();
        fire(3);
        run_wait();
        rd_chk(`RCIV_ADDR_CAUSE, 8'h30);
        wr(`RCIV_ADDR_CAUSE, 8'hFF);
        rd_chk(`RCIV_ADDR_CAUSE, 8'h00);
    endtask
    task t_halt();
        fire(1);
        run_wait();
        rd_chk(`RCIV_ADDR_CAUSE, 8'h10);
        wr(`RCIV_ADDR_CTRL, 8'h01);
        rd_chk(`RCIV_ADDR_CTRL, 8'h01);
        fire(1);
        repeat (80) @(posedge clk);
        chk(cpu_reset, 1'b0);
        wr(`RCIV_ADDR_CTRL, 8'h00);
    endtask
    task t_fetch();
        @(posedge clk);
        data_rd_bad <= 1'b1;
        @(posedge clk);
        data_rd_bad <= 1'b0;
        repeat (10) @(posedge clk);
        chk(cpu_reset, 1'b0);
        fire(2);
        run_wait();
        rd_chk(`RCIV_ADDR_CAUSE, 8'h08);
    endtask
    task t_pin_brown();
        pin_ext_n <= 1'b0;
        fire(0);
        run_wait();
        pin_ext_n <= 1'b1;
        repeat (5) @(posedge clk);
        rd_chk(`RCIV_ADDR_CAUSE, 8'h50);
        brownout_n <= 1'b0;
        repeat (10) @(posedge clk);
        brownout_n <= 1'b1;
        run_wait();
        rd_chk(`RCIV_ADDR_CAUSE, 8'h02);
    endtask
    task t_irq();
        src(16'h8001, 16'h8001, 1'b0);
        rd_chk(`RCIV_ADDR_PEND, 8'h01);
        rd_chk(`RCIV_ADDR_PEND_HI, 8'h80);
        irq(1'b0, 1'b0, `RCIV_VEC_TOP, 5'h01, 16'h1233);
        irq(1'b0, 1'b1, `RCIV_VEC_TOP, 5'h01, 16'h1233);
        src(16'h8001, 16'h8001, 1'b1);
        irq(1'b0, 1'b0, 16'h0000, 5'h00, 16'h0000);
        irq(1'b1, 1'b0, `RCIV_VEC_TRAP, 5'h00, 16'h1234);
        src(16'h8000, 16'h0000, 1'b0);
        irq(1'b0, 1'b0, 16'h0000, 5'h00, 16'h0000);
        src(16'h8000, 16'h8000, 1'b0);
        irq(1'b0, 1'b0, 16'hFFDC, 5'h10, 16'h1233);
        src(16'h4000, 16'h4000, 1'b0);
        irq(1'b0, 1'b0, 16'hFFDE, 5'h0F, 16'h1233);
        src(16'h2000, 16'h2000, 1'b0);
        irq(1'b0, 1'b0, 16'hFFDE, 5'h0E, 16'h1233);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task print_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // The whole sequence needs about 740 clocks; the ceiling leaves margin.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        t_por();
        t_accum();
        t_halt();
        t_fetch();
        t_pin_brown();
        t_irq();
        print_verdict();
    end
endmodule
